// file: bench/adc_cmos_output_interface_tb.sv
// self-checking bench for the converter parallel output block
`timescale 1ns/100ps
module adc_cmos_output_interface_tb;
  import adcif_pkg::*;
  // ------------------------------------------------------------
  // stimulus and wiring
  // ------------------------------------------------------------
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic pos = 1'b0;
  logic neg = 1'b1;
  logic [1:0] style = 2'h0;
  logic [1:0] fmt = 2'h0;
  logic [9:0] code = 10'h000;
  logic rng = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hready;
  logic hresp;
  logic [9:0] fd;
  logic [9:0] sd;
  logic fdo, fr, fro, fs, fso, sdo, sr, sro, ss, sso, nap, slp, stab, irq;
  logic rx_clear = 1'b0;
  logic [3:0] left = 4'h0;
  logic [2:0] ph = 3'h0;
  logic [10:0] sent_q[$];
  int fail_count = 0;
  int comparisons = 0;
  logic [31:0] rd;
  logic [31:0] cnt0;
  wire [9:0] nxt = code + 10'h001;
  localparam logic [31:0] A_CTRL = 32'(ADCIF_OFS_CTRL);
  localparam logic [31:0] A_STAT = 32'(ADCIF_OFS_STATUS);
  localparam logic [31:0] A_INT = 32'(ADCIF_OFS_INT_STATUS);
  localparam logic [31:0] A_MASK = 32'(ADCIF_OFS_INT_MASK);
  localparam logic [31:0] A_CNT = 32'(ADCIF_OFS_SAMPLE_COUNT);

  initial begin
    forever #10 clk = ~clk;
  end

  adcif_top dut (.I_CLK(clk), .I_SRST(srst), .I_ENCODE_POS(pos), .I_ENCODE_NEG(neg),
    .I_OUTPUT_STYLE_STRAP(style), .I_FORMAT_STRAP(fmt), .I_CORE_CODE(code), .I_CORE_RANGE(rng),
    .O_FIRST_BUS_DATA(fd), .O_FIRST_BUS_DATA_OE_N(fdo), .O_FIRST_BUS_RANGE_FLAG(fr),
    .O_FIRST_BUS_RANGE_FLAG_OE_N(fro), .O_FIRST_BUS_STROBE(fs), .O_FIRST_BUS_STROBE_OE_N(fso),
    .O_SECOND_BUS_DATA(sd), .O_SECOND_BUS_DATA_OE_N(sdo), .O_SECOND_BUS_RANGE_FLAG(sr),
    .O_SECOND_BUS_RANGE_FLAG_OE_N(sro), .O_SECOND_BUS_STROBE(ss), .O_SECOND_BUS_STROBE_OE_N(sso),
    .O_NAP(nap), .O_SLEEP(slp), .O_STABILIZER_ON(stab), .O_IRQ(irq), .I_HSEL(hsel), .I_HADDR(haddr),
    .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata), .I_HREADY(hready),
    .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(hresp));

  adcif_rx_model rx (.i_clk(clk), .i_clear(rx_clear), .i_second_rise(style == ADCIF_STYLE_SIMUL),
    .i_first_data(fd), .i_first_oe_n(fdo), .i_first_range(fr), .i_first_strobe(fs),
    .i_second_data(sd), .i_second_oe_n(sdo), .i_second_range(sr), .i_second_strobe(ss));

  // encode period of 8 clocks, still between bursts
  always @(posedge clk) begin
    if (ph != 3'h0 || left != 4'h0) begin
      ph <= ph + 3'h1;
      if (ph == 3'h0) begin
        pos <= 1'b1;
        neg <= 1'b0;
        code <= nxt;
        rng <= (nxt[1:0] == 2'h3);
        left <= left - 4'h1;
        sent_q.push_back({nxt[1:0] == 2'h3, nxt});
      end
      if (ph == 3'h4) begin
        pos <= 1'b0;
        neg <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
    chk(hresp, 1'b0);
  endtask

  task enc(input logic [3:0] n);
    left <= n;
    @(posedge clk);
    while (left != 4'h0 || ph != 3'h0) @(posedge clk);
    repeat (16) @(posedge clk);
  endtask

  // conversions must stay off in this state
  task none_taken;
    ahb(1'b0, A_CNT, 32'h0);
    cnt0 = rd;
    enc(4'h3);
    ahb(1'b0, A_CNT, 32'h0);
    chk(rd, cnt0);
  endtask

  task automatic run(input logic [1:0] st, input logic [1:0] fm, input logic [9:0] base);
    logic [10:0] ef[$];
    logic [10:0] es[$];
    logic [10:0] v;
    logic on;
    style <= st;
    fmt <= fm;
    code <= base - 10'h001;
    rx_clear <= 1'b1;
    repeat (8) @(posedge clk);
    rx_clear <= 1'b0;
    sent_q.delete();
    on = (fm == ADCIF_FMT_OB_STAB_ON || fm == ADCIF_FMT_TC_STAB_ON);
    ahb(1'b0, A_STAT, 32'h0);
    chk(rd[6:0], {on, 2'h0, fm, st});
    chk(stab, on);
    ahb(1'b0, A_CNT, 32'h0);
    cnt0 = rd;
    enc(4'h9);
    ahb(1'b0, A_CNT, 32'h0);
    chk(rd - cnt0, 32'h9);
    foreach (sent_q[i]) begin
      v = sent_q[i];
      if (fm[1]) v[9] = ~v[9];
      // last demux word never sees the strobe edge that closes it
      if (st != ADCIF_STYLE_FULL && i == 8) continue;
      if (st == ADCIF_STYLE_FULL || i % 2 == 0) ef.push_back(v);
      else es.push_back(v);
    end
    chk(rx.first_q.size(), ef.size());
    foreach (ef[i]) if (i < rx.first_q.size()) chk(rx.first_q[i], ef[i]);
    if (st != ADCIF_STYLE_FULL) chk(rx.second_q.size(), es.size());
    foreach (es[i]) if (i < rx.second_q.size()) chk(rx.second_q[i], es[i]);
    chk({sdo, sro, sso, fdo, fro, fso}, {st == ADCIF_STYLE_FULL, st == ADCIF_STYLE_FULL, 4'b0000});
  endtask

  task print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // test sequence
  // ------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    repeat (6) @(posedge clk);
    ahb(1'b0, A_CTRL, 32'h0);
    chk(rd, 32'h0);
    ahb(1'b0, A_MASK, 32'h0);
    chk(rd, 32'h0);
    ahb(1'b1, 32'h14, 32'hffffffff);
    ahb(1'b0, 32'h14, 32'h0);
    chk(rd, 32'h0);
    run(ADCIF_STYLE_FULL, ADCIF_FMT_OB_STAB_OFF, 10'h3fa);
    ahb(1'b0, A_INT, 32'h0);
    chk(rd[1:0], 2'h3);
    chk(irq, 1'b0);
    ahb(1'b1, A_MASK, 32'h1);
    @(posedge clk);
    chk(irq, 1'b1);
    ahb(1'b1, A_INT, 32'h7);
    @(posedge clk);
    chk(irq, 1'b0);
    ahb(1'b0, A_INT, 32'h0);
    chk(rd, 32'h0);
    ahb(1'b1, A_MASK, 32'h0);
    run(ADCIF_STYLE_INTER, ADCIF_FMT_OB_STAB_ON, 10'h3fe);
    run(ADCIF_STYLE_FULL, ADCIF_FMT_TC_STAB_ON, 10'h1fc);
    run(ADCIF_STYLE_SIMUL, ADCIF_FMT_TC_STAB_OFF, 10'h200);
    style <= ADCIF_STYLE_DIFF;
    repeat (8) @(posedge clk);
    chk(fdo, 1'b1);
    none_taken;
    style <= ADCIF_STYLE_FULL;
    ahb(1'b1, A_CTRL, 32'h2);
    repeat (2) @(posedge clk);
    chk({slp, nap, fdo, sso}, 4'b0011);
    ahb(1'b1, A_CTRL, 32'h1);
    repeat (2) @(posedge clk);
    chk({slp, nap, fdo, sso}, 4'b0111);
    none_taken;
    ahb(1'b1, A_CTRL, 32'h3);
    repeat (2) @(posedge clk);
    chk({slp, nap, fdo, sso}, 4'b1011);
    ahb(1'b0, A_STAT, 32'h0);
    chk(rd[5:4], 2'h3);
    ahb(1'b1, A_CTRL, 32'h0);
    repeat (2) @(posedge clk);
    chk({slp, nap, fdo, sso}, 4'b0000);
    print_verdict;
  end

  // hang guard, far beyond the few hundred cycles used
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    print_verdict;
  end
endmodule

// file: bench/adcif_rx_model.sv
// capture model of the receiving logic on both output buses
`timescale 1ns/100ps
module adcif_rx_model (
  input wire logic i_clk,
  input wire logic i_clear,
  input wire logic i_second_rise,
  input wire logic [9:0] i_first_data,
  input wire logic i_first_oe_n,
  input wire logic i_first_range,
  input wire logic i_first_strobe,
  input wire logic [9:0] i_second_data,
  input wire logic i_second_oe_n,
  input wire logic i_second_range,
  input wire logic i_second_strobe
);
  // ------------------------------------------------------------
  // capture queues
  // ------------------------------------------------------------
  logic [10:0] first_q[$];
  logic [10:0] second_q[$];
  logic [10:0] first_last = 11'h000;
  logic [10:0] second_last = 11'h000;
  logic first_prev = 1'b0;
  logic second_prev = 1'b0;
  // a floated bus toggles, so a stale word never looks valid
  wire [10:0] first_seen = i_first_oe_n ? ~first_last : {i_first_range, i_first_data};
  wire [10:0] second_seen = i_second_oe_n ? ~second_last : {i_second_range, i_second_data};
  wire second_edge = i_second_rise ? (!second_prev && i_second_strobe) : (second_prev && !i_second_strobe);
  always @(posedge i_clk) begin
    if (i_clear) begin
      first_q.delete();
      second_q.delete();
    end else begin
      if (first_prev && !i_first_strobe) first_q.push_back(first_seen);
      // second bus edge by update style
      if (second_edge) second_q.push_back(second_seen);
    end
    first_prev <= i_first_strobe;
    second_prev <= i_second_strobe;
    first_last <= first_seen;
    second_last <= second_seen;
  end
endmodule

// file: src/adcif_pkg.sv
// shared constants and types for the converter parallel output block
package adcif_pkg;

  // ------------------------------------------------------------
  // data and bus geometry
  // ------------------------------------------------------------
  localparam int ADCIF_DATA_W = 10;
  localparam int ADCIF_HADDR_W = 32;
  localparam int ADCIF_HDATA_W = 32;
  localparam int ADCIF_SYNC_W = 6;

  // ------------------------------------------------------------
  // register offsets (byte addresses, low address bits)
  // ------------------------------------------------------------
  localparam logic [7:0] ADCIF_OFS_CTRL = 8'h00;
  localparam logic [7:0] ADCIF_OFS_STATUS = 8'h04;
  localparam logic [7:0] ADCIF_OFS_INT_STATUS = 8'h08;
  localparam logic [7:0] ADCIF_OFS_INT_MASK = 8'h0c;
  localparam logic [7:0] ADCIF_OFS_SAMPLE_COUNT = 8'h10;

  // ------------------------------------------------------------
  // control register fields and reset values
  // ------------------------------------------------------------
  localparam int ADCIF_CTRL_PD_BIT = 0;
  localparam int ADCIF_CTRL_OE_N_BIT = 1;
  localparam logic ADCIF_CTRL_PD_RST = 1'b0;
  localparam logic ADCIF_CTRL_OE_N_RST = 1'b0;

  // ------------------------------------------------------------
  // status register fields
  // ------------------------------------------------------------
  localparam int ADCIF_STAT_STYLE_LSB = 0;
  localparam int ADCIF_STAT_FORMAT_LSB = 2;
  localparam int ADCIF_STAT_PWR_LSB = 4;
  localparam int ADCIF_STAT_STAB_BIT = 6;
  localparam int ADCIF_STAT_BANK_BIT = 7;

  // ------------------------------------------------------------
  // interrupt bits (status and mask share the layout)
  // ------------------------------------------------------------
  localparam int ADCIF_INT_W = 3;
  localparam int ADCIF_INT_SAMPLE_BIT = 0;
  localparam int ADCIF_INT_FIRST_RANGE_BIT = 1;
  localparam int ADCIF_INT_SECOND_RANGE_BIT = 2;
  localparam logic [ADCIF_INT_W-1:0] ADCIF_INT_MASK_RST = 3'h0;

  // ------------------------------------------------------------
  // strap decodes and power states
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    ADCIF_STYLE_FULL = 2'h0,
    ADCIF_STYLE_SIMUL = 2'h1,
    ADCIF_STYLE_INTER = 2'h2,
    ADCIF_STYLE_DIFF = 2'h3
  } adcif_style_type;

  typedef enum logic [1:0] {
    ADCIF_FMT_OB_STAB_OFF = 2'h0,
    ADCIF_FMT_OB_STAB_ON = 2'h1,
    ADCIF_FMT_TC_STAB_ON = 2'h2,
    ADCIF_FMT_TC_STAB_OFF = 2'h3
  } adcif_format_type;

  typedef enum logic [1:0] {
    ADCIF_PWR_RUN = 2'b00,
    ADCIF_PWR_NAP = 2'b01,
    ADCIF_PWR_SLEEP = 2'b11
  } adcif_pwr_type;

endpackage

// file: src/adcif_sync.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
module adcif_sync #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;

  // ------------------------------------------------------------
  // chain; a bit changes only once stages two and three agree
  // ------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      o_sync <= '0;
    end else begin
      stage1 <= i_async;
      stage2 <= stage1;
      stage3 <= stage2;
      o_sync <= (stage2 & stage3) | (o_sync & (stage2 ^ stage3));
    end
  end
endmodule

// file: src/adcif_top.sv
// converter parallel output interface with register slave
//
// Function
// R1 - a conversion starts when the positive encode rises and the complementary encode falls, once per period.
// R2 - with power-down low the block converts and drives outputs when output enable is low, floats them when high.
// R3 - with power-down high the block naps when output enable is low, sleeps when high, outputs floated in both.
// R4 - a second ten-bit bus with msb on top exists and floats in full-rate single-bus mode.
// R5 - the second bus range flag marks an out-of-range sample on that bus and floats in full-rate mode.
// R6 - in interleaved mode the receiver latches second-bus data on the falling second strobe edge.
// R7 - in simultaneous mode the receiver latches second-bus data on the rising second strobe edge.
// R8 - the second bus strobe stays driven in full-rate mode.
// R9 - the receiver latches first-bus data on the falling first strobe edge in every mode.
// R10 - a first ten-bit bus with msb on top is active in all parallel modes.
// R11 - the first bus range flag marks an out-of-range sample on that bus.
// R12 - the output-style strap levels select full rate, simultaneous, interleaved or differential output.
// R13 - the format strap levels select offset binary or two's complement and the stabilizer state.
// R14 - in two's complement just above zero is all zeros and just below zero is all ones.
// R15 - in demultiplexed modes successive samples alternate between the first and second buses.
//
// Our own choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/100ps
module adcif_top
  import adcif_pkg::*;
#(
  parameter int DATA_W = 10
) (
  input wire logic I_CLK,
  input wire logic I_SRST,
  input wire logic I_ENCODE_POS,
  input wire logic I_ENCODE_NEG,
  input wire logic [1:0] I_OUTPUT_STYLE_STRAP,
  input wire logic [1:0] I_FORMAT_STRAP,
  input wire logic [DATA_W-1:0] I_CORE_CODE,
  input wire logic I_CORE_RANGE,
  output logic [DATA_W-1:0] O_FIRST_BUS_DATA,
  output logic O_FIRST_BUS_DATA_OE_N,
  output logic O_FIRST_BUS_RANGE_FLAG,
  output logic O_FIRST_BUS_RANGE_FLAG_OE_N,
  output logic O_FIRST_BUS_STROBE,
  output logic O_FIRST_BUS_STROBE_OE_N,
  output logic [DATA_W-1:0] O_SECOND_BUS_DATA,
  output logic O_SECOND_BUS_DATA_OE_N,
  output logic O_SECOND_BUS_RANGE_FLAG,
  output logic O_SECOND_BUS_RANGE_FLAG_OE_N,
  output logic O_SECOND_BUS_STROBE,
  output logic O_SECOND_BUS_STROBE_OE_N,
  output logic O_NAP,
  output logic O_SLEEP,
  output logic O_STABILIZER_ON,
  output logic O_IRQ,
  input wire logic I_HSEL,
  input wire logic [adcif_pkg::ADCIF_HADDR_W-1:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic [2:0] I_HSIZE,
  input wire logic [adcif_pkg::ADCIF_HDATA_W-1:0] I_HWDATA,
  input wire logic I_HREADY,
  output logic [adcif_pkg::ADCIF_HDATA_W-1:0] O_HRDATA,
  output logic O_HREADYOUT,
  output logic O_HRESP
);
  import adcif_pkg::*;

  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (I_SRST);

  // ------------------------------------------------------------
  // pin synchronisation and strap decode
  // ------------------------------------------------------------
  logic [ADCIF_SYNC_W-1:0] pins_sync;
  logic enc_lvl;
  logic enc_lvl_q;
  logic enc_rise;
  logic enc_fall;
  adcif_style_type style;
  adcif_format_type fmt;
  logic fmt_twos;
  logic demux;

  adcif_sync #(
    .W(ADCIF_SYNC_W)
  ) u_pin_sync (
    .i_clk(I_CLK),
    .i_srst(I_SRST),
    .i_async({I_FORMAT_STRAP, I_OUTPUT_STYLE_STRAP, I_ENCODE_NEG, I_ENCODE_POS}),
    .o_sync(pins_sync)
  );

  // R1 differential encode edge
  assign enc_lvl = pins_sync[0] & ~pins_sync[1];
  assign enc_rise = enc_lvl & ~enc_lvl_q;
  assign enc_fall = ~enc_lvl & enc_lvl_q;
  // R12 style strap levels
  assign style = adcif_style_type'(pins_sync[3:2]);
  // R13 format strap levels
  assign fmt = adcif_format_type'(pins_sync[5:4]);
  assign fmt_twos = (fmt == ADCIF_FMT_TC_STAB_ON) || (fmt == ADCIF_FMT_TC_STAB_OFF);
  assign demux = (style == ADCIF_STYLE_SIMUL) || (style == ADCIF_STYLE_INTER);

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      enc_lvl_q <= 1'b0;
    end else begin
      enc_lvl_q <= enc_lvl;
    end
  end

  // ------------------------------------------------------------
  // control registers and power state
  // ------------------------------------------------------------
  logic ctrl_pd;
  logic ctrl_oe_n;
  adcif_pwr_type pwr_state;
  adcif_pwr_type next_pwr_state;

  // R3 nap or sleep picked by the enable level
  assign next_pwr_state = !ctrl_pd ? ADCIF_PWR_RUN : (ctrl_oe_n ? ADCIF_PWR_SLEEP : ADCIF_PWR_NAP);

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      pwr_state <= ADCIF_PWR_RUN;
    end else begin
      pwr_state <= next_pwr_state;
    end
  end

  assign O_NAP = (pwr_state == ADCIF_PWR_NAP);
  assign O_SLEEP = (pwr_state == ADCIF_PWR_SLEEP);
  assign O_STABILIZER_ON = (fmt == ADCIF_FMT_OB_STAB_ON) || (fmt == ADCIF_FMT_TC_STAB_ON);

  // ------------------------------------------------------------
  // conversion, format and bus steering
  // ------------------------------------------------------------
  logic conv;
  logic [DATA_W-1:0] code_fmt;
  logic bank;
  logic sim_fresh;
  logic [DATA_W-1:0] hold_code;
  logic hold_rng;
  logic upd_first;
  logic upd_second;

  // differential style has no parallel outputs, so nothing converts here
  assign conv = enc_rise && (pwr_state == ADCIF_PWR_RUN) && (style != ADCIF_STYLE_DIFF);
  // R14 msb flip turns offset binary into two's complement
  assign code_fmt = fmt_twos ? {~I_CORE_CODE[DATA_W-1], I_CORE_CODE[DATA_W-2:0]} : I_CORE_CODE;
  assign upd_first = conv && (!demux || !bank || (style == ADCIF_STYLE_SIMUL));
  assign upd_second = conv && demux && bank;

  // R15 alternate banks in demultiplexed modes
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      bank <= 1'b0;
    end else if (!demux) begin
      bank <= 1'b0;
    end else if (conv) begin
      bank <= ~bank;
    end
  end

  // R10 first bus takes each full-rate or bank-zero sample
  // R11 range flag travels with its sample
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      O_FIRST_BUS_DATA <= '0;
      O_FIRST_BUS_RANGE_FLAG <= 1'b0;
      hold_code <= '0;
      hold_rng <= 1'b0;
    end else if (conv && style == ADCIF_STYLE_SIMUL && !bank) begin
      hold_code <= code_fmt;
      hold_rng <= I_CORE_RANGE;
    end else if (upd_first && style == ADCIF_STYLE_SIMUL) begin
      O_FIRST_BUS_DATA <= hold_code;
      O_FIRST_BUS_RANGE_FLAG <= hold_rng;
    end else if (upd_first) begin
      O_FIRST_BUS_DATA <= code_fmt;
      O_FIRST_BUS_RANGE_FLAG <= I_CORE_RANGE;
    end
  end

  // R4 second bus takes bank-one samples
  // R5 its range flag follows the same sample
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      O_SECOND_BUS_DATA <= '0;
      O_SECOND_BUS_RANGE_FLAG <= 1'b0;
    end else if (upd_second) begin
      O_SECOND_BUS_DATA <= code_fmt;
      O_SECOND_BUS_RANGE_FLAG <= I_CORE_RANGE;
    end
  end

  // ------------------------------------------------------------
  // data valid strobes
  // ------------------------------------------------------------
  // falling edges land mid-way through a stable word, three quarters through it in simultaneous mode;
  // simultaneous strobes rise half a period after the pair update
  // R6 interleaved second strobe falls when the first bus updates
  // R7 simultaneous strobe rises well after the pair update
  // R9 first strobe falls only while its word is stable
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      O_FIRST_BUS_STROBE <= 1'b0;
      O_SECOND_BUS_STROBE <= 1'b0;
      sim_fresh <= 1'b0;
    end else if (style == ADCIF_STYLE_SIMUL) begin
      if (upd_second) begin
        sim_fresh <= 1'b1;
      end else if (enc_fall) begin
        sim_fresh <= 1'b0;
        O_FIRST_BUS_STROBE <= sim_fresh;
        O_SECOND_BUS_STROBE <= sim_fresh;
      end
    end else if (style == ADCIF_STYLE_INTER) begin
      sim_fresh <= 1'b0;
      if (conv) begin
        O_FIRST_BUS_STROBE <= ~bank;
        O_SECOND_BUS_STROBE <= bank;
      end
    end else begin
      sim_fresh <= 1'b0;
      if (conv) begin
        O_FIRST_BUS_STROBE <= 1'b1;
        O_SECOND_BUS_STROBE <= 1'b1;
      end else if (enc_fall) begin
        O_FIRST_BUS_STROBE <= 1'b0;
        O_SECOND_BUS_STROBE <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // output enables (low while driving)
  // ------------------------------------------------------------
  logic out_on;
  logic second_on;

  // R2 drive only while running with the enable low
  assign out_on = (pwr_state == ADCIF_PWR_RUN) && !ctrl_oe_n && (style != ADCIF_STYLE_DIFF);
  // R4 second bus floats in full-rate mode
  assign second_on = out_on && (style != ADCIF_STYLE_FULL);
  assign O_FIRST_BUS_DATA_OE_N = ~out_on;
  assign O_FIRST_BUS_RANGE_FLAG_OE_N = ~out_on;
  assign O_FIRST_BUS_STROBE_OE_N = ~out_on;
  assign O_SECOND_BUS_DATA_OE_N = ~second_on;
  // R5 range flag floats with its bus
  assign O_SECOND_BUS_RANGE_FLAG_OE_N = ~second_on;
  // R8 strobe stays driven in full-rate mode
  assign O_SECOND_BUS_STROBE_OE_N = ~out_on;

  // ------------------------------------------------------------
  // interrupts and sample counter
  // ------------------------------------------------------------
  logic [ADCIF_INT_W-1:0] int_status;
  logic [ADCIF_INT_W-1:0] int_mask;
  logic [ADCIF_INT_W-1:0] int_set;
  logic [ADCIF_INT_W-1:0] int_clr;
  logic [ADCIF_HDATA_W-1:0] sample_count;

  assign int_set[ADCIF_INT_SAMPLE_BIT] = conv;
  assign int_set[ADCIF_INT_FIRST_RANGE_BIT] = upd_first && I_CORE_RANGE && style != ADCIF_STYLE_SIMUL;
  assign int_set[ADCIF_INT_SECOND_RANGE_BIT] = upd_second && I_CORE_RANGE;
  assign O_IRQ = |(int_status & int_mask);

  // set wins over a same-cycle clear
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      int_status <= '0;
      sample_count <= '0;
    end else begin
      int_status <= (int_status & ~int_clr) | int_set;
      sample_count <= sample_count + (conv ? 32'h1 : 32'h0);
    end
  end

  // ------------------------------------------------------------
  // register slave, zero wait states
  // ------------------------------------------------------------
  logic acc_valid;
  logic acc_rd;
  logic wr_pend;
  logic [7:0] wr_addr;
  logic [7:0] acc_addr;
  logic [ADCIF_HDATA_W-1:0] rd_mux;
  logic [ADCIF_HDATA_W-1:0] status_word;

  assign acc_valid = I_HSEL && I_HREADY && I_HTRANS[1];
  assign acc_rd = acc_valid && !I_HWRITE;
  assign acc_addr = {I_HADDR[7:2], 2'b00};
  assign O_HREADYOUT = 1'b1;
  assign O_HRESP = 1'b0;
  assign int_clr = (wr_pend && wr_addr == ADCIF_OFS_INT_STATUS) ? I_HWDATA[ADCIF_INT_W-1:0] : '0;
  assign status_word = {24'h0, bank, O_STABILIZER_ON, pwr_state, fmt, style};
  assign rd_mux = (acc_addr == ADCIF_OFS_CTRL) ? {30'h0, ctrl_oe_n, ctrl_pd} :
                  (acc_addr == ADCIF_OFS_STATUS) ? status_word :
                  (acc_addr == ADCIF_OFS_INT_STATUS) ? {29'h0, int_status} :
                  (acc_addr == ADCIF_OFS_INT_MASK) ? {29'h0, int_mask} :
                  (acc_addr == ADCIF_OFS_SAMPLE_COUNT) ? sample_count : 32'h0;

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      O_HRDATA <= 32'h0;
    end else begin
      wr_pend <= acc_valid && I_HWRITE;
      wr_addr <= acc_addr;
      O_HRDATA <= acc_rd ? rd_mux : 32'h0;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      ctrl_pd <= ADCIF_CTRL_PD_RST;
      ctrl_oe_n <= ADCIF_CTRL_OE_N_RST;
      int_mask <= ADCIF_INT_MASK_RST;
    end else if (wr_pend && wr_addr == ADCIF_OFS_CTRL) begin
      ctrl_pd <= I_HWDATA[ADCIF_CTRL_PD_BIT];
      ctrl_oe_n <= I_HWDATA[ADCIF_CTRL_OE_N_BIT];
    end else if (wr_pend && wr_addr == ADCIF_OFS_INT_MASK) begin
      int_mask <= I_HWDATA[ADCIF_INT_W-1:0];
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  conv_on_edge_a: assert property (conv |-> pins_sync[0] && !pins_sync[1] && !$past(enc_lvl)) // R1
    else $error("conversion without encode edge");
  conv_single_a: assert property (conv |=> !conv) // R1
    else $error("two conversions in one encode period");
  drive_normal_a: assert property (($past(ctrl_pd) == 1'b0) && !ctrl_oe_n && style != ADCIF_STYLE_DIFF
    |-> !O_FIRST_BUS_DATA_OE_N && !O_FIRST_BUS_STROBE_OE_N) // R2
    else $error("outputs not driven in normal operation");
  float_enable_a: assert property (ctrl_oe_n |-> O_FIRST_BUS_DATA_OE_N && O_SECOND_BUS_STROBE_OE_N) // R2
    else $error("outputs driven while enable is high");
  nap_sleep_a: assert property (ctrl_pd |=> (ctrl_oe_n ? (O_SLEEP && !O_NAP) : (O_NAP && !O_SLEEP))
    || $changed(ctrl_oe_n)) // R3
    else $error("wrong low power state");
  pd_float_a: assert property ((O_NAP || O_SLEEP) |-> O_FIRST_BUS_RANGE_FLAG_OE_N && O_SECOND_BUS_DATA_OE_N
    && !conv) // R3
    else $error("outputs or conversion active in low power");
  full_float_a: assert property (style == ADCIF_STYLE_FULL |-> O_SECOND_BUS_DATA_OE_N
    && O_SECOND_BUS_RANGE_FLAG_OE_N && (O_SECOND_BUS_STROBE_OE_N == O_FIRST_BUS_STROBE_OE_N)) // R8
    else $error("second bus enables wrong in full-rate mode");
  first_update_a: assert property (conv && style == ADCIF_STYLE_FULL && $stable(style)
    |=> O_FIRST_BUS_DATA == $past(code_fmt) && O_FIRST_BUS_RANGE_FLAG == $past(I_CORE_RANGE)) // R11
    else $error("first bus not loaded with sample");
  twos_zero_a: assert property (conv && fmt_twos && style == ADCIF_STYLE_FULL
    && I_CORE_CODE == 10'h1ff |=> O_FIRST_BUS_DATA == 10'h3ff) // R14
    else $error("below-zero code not all ones");
  bank_alt_a: assert property (conv && demux && $stable(style) |=> bank != $past(bank)) // R15
    else $error("demux bank did not alternate");
endmodule
